// *** rtl/lmrt_condition.sv ***
module lmrt_condition (
  // sample in
  input  wire logic signed [lmrt_pkg::SAMPLE_W:0]  sample_i,
  // controls
  input  wire logic                                gain_sixteen_select_i,
  input  wire logic                                rectifier_enable_i,
  // conditioned sample
  output logic signed [lmrt_pkg::COND_W-1:0]       cond_o
);
  import lmrt_pkg::*;

  logic signed [COND_W-1:0] ext_s;     // sign-extended input
  logic signed [COND_W-1:0] gained_s;  // after gain stage

  ////////////////////////////////////////////////////////////////////////////
  // gain then rectifier; width leaves headroom so neither step wraps
  always_comb begin
    ext_s    = COND_W'(sample_i);
    gained_s = gain_sixteen_select_i ? (ext_s <<< GAIN_SHIFT) : ext_s;  // [R11]
    if (rectifier_enable_i && gained_s < 0) begin
      cond_o = -gained_s;   // negative samples folded up [R12]
    end else begin
      cond_o = gained_s;    // unchanged when rectifier off [R12]
    end
  end

endmodule

// *** rtl/lmrt_meter.sv ***
// Overview of operation
// [R1] result sixteen bit, low and high bytes
// [R2] result spans 0x8000 through 0x7FFF
// [R3] 27-bit integrator, scaled before result
// [R4] shift codes 0..10 by 2^n, else 2048
// [R5] latched result magnitude compared, flag set
// [R6] threshold code times 12.5 percent full scale
// [R7] channel select picks meter input channel
// [R8] integration length count plus one samples
// [R9] enable one starts, zero stops measurement
// [R10] done flag set at integration end
// [R11] gain select multiplies by one or sixteen
// [R12] rectifier folds negative samples when enabled
// [R13] mode picks single or continuous integration
// [R14] offset from coefficient word or zero
// [R15] filter bypass or insert, notch or bandpass
// [R16] coefficient source ram or rom, rom default
// [R17] source ac, receive dc or transmit dc
// [R18] continuous restarts, flag self-clears after 125us
// [R19] single flag holds until enable cleared
// [R20] result registers updated every integration end
// [R21] arithmetic shift then cut to sixteen
module lmrt_meter (
  // clock and reset
  input  wire logic                                            ref_clk_i,
  input  wire logic                                            rst_i,
  // sample timing and data
  input  wire logic                                            sample_strobe_i,
  input  wire logic [lmrt_pkg::CH_N-1:0][lmrt_pkg::SAMPLE_W-1:0] transmit_ac_signal_i,
  input  wire logic [lmrt_pkg::CH_N-1:0][lmrt_pkg::SAMPLE_W-1:0] receive_dc_signal_i,
  input  wire logic [lmrt_pkg::CH_N-1:0][lmrt_pkg::SAMPLE_W-1:0] transmit_dc_signal_i,
  input  wire logic [lmrt_pkg::SAMPLE_W-1:0]                   filtered_ac_i,
  input  wire logic [lmrt_pkg::SAMPLE_W-1:0]                   dc_offset_word_i,
  // configuration load
  input  wire logic                                            cfg_load_i,
  input  wire logic                                            meter_enable_i,
  input  wire logic [1:0]                                      meter_channel_select_i,
  input  wire logic                                            meter_ac_dc_select_i,
  input  wire logic                                            dc_path_select_i,
  input  wire logic [3:0]                                      dc_input_select_i,
  input  wire logic [lmrt_pkg::CNT_W-1:0]                      integration_count_i,
  input  wire logic [3:0]                                      shift_factor_code_i,
  input  wire logic [2:0]                                      threshold_code_i,
  input  wire logic                                            gain_sixteen_select_i,
  input  wire logic                                            rectifier_enable_i,
  input  wire logic                                            single_run_select_i,
  input  wire logic                                            offset_source_select_i,
  input  wire logic                                            tunable_filter_enable_i,
  input  wire logic                                            filter_shape_select_i,
  input  wire logic                                            bandpass_coef_source_i,
  input  wire logic                                            notch_coef_source_i,
  // results and status
  output logic [7:0]                                           result_low_bits_o,
  output logic [7:0]                                           result_high_bits_o,
  output logic                                                 over_threshold_flag_o,
  output logic                                                 measurement_done_flag_o,
  output logic                                                 measurement_done_event_o,
  // steering of outside filter and dc mux
  output logic [lmrt_pkg::SAMPLE_W-1:0]                        meter_ac_sample_o,
  output logic                                                 tunable_filter_enable_o,
  output logic                                                 filter_shape_select_o,
  output logic                                                 filter_coef_from_rom_o,
  output logic [1:0]                                           meter_channel_o,
  output logic [3:0]                                           dc_input_select_o
);
  import lmrt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // configuration state
  logic             en_r,     en_nxt;      // meter enable
  logic [1:0]       ch_r,     ch_nxt;      // channel select
  logic             acsel_r,  acsel_nxt;   // ac vs dc
  logic             dcsel_r,  dcsel_nxt;   // receive vs transmit dc
  logic [3:0]       dcin_r,   dcin_nxt;    // transmit dc input
  logic [CNT_W-1:0] count_r,  count_nxt;   // integration count
  logic [3:0]       shift_r,  shift_nxt;   // shift code
  logic [2:0]       thr_r,    thr_nxt;     // threshold code
  logic             gain_r,   gain_nxt;    // gain of 16
  logic             rect_r,   rect_nxt;    // rectifier on
  logic             single_r, single_nxt;  // single run
  logic             ofsel_r,  ofsel_nxt;   // offset zero
  logic             filt_r,   filt_nxt;    // filter inserted
  logic             shape_r,  shape_nxt;   // bandpass when set
  logic             bpsrc_r,  bpsrc_nxt;   // bandpass from rom
  logic             nsrc_r,   nsrc_nxt;    // notch from rom

  // fields change only on a load; the meter sees a consistent set
  always_comb begin
    {en_nxt, ch_nxt, acsel_nxt, dcsel_nxt, dcin_nxt, count_nxt, shift_nxt, thr_nxt} =
      {en_r, ch_r, acsel_r, dcsel_r, dcin_r, count_r, shift_r, thr_r};
    {gain_nxt, rect_nxt, single_nxt, ofsel_nxt, filt_nxt, shape_nxt, bpsrc_nxt, nsrc_nxt} =
      {gain_r, rect_r, single_r, ofsel_r, filt_r, shape_r, bpsrc_r, nsrc_r};
    if (cfg_load_i) begin
      en_nxt = meter_enable_i;  // [R9]
      {ch_nxt, acsel_nxt, dcsel_nxt, dcin_nxt, count_nxt, shift_nxt, thr_nxt} = {meter_channel_select_i,
        meter_ac_dc_select_i, dc_path_select_i, dc_input_select_i, integration_count_i, shift_factor_code_i,
        threshold_code_i};
      {gain_nxt, rect_nxt, single_nxt, ofsel_nxt, filt_nxt, shape_nxt, bpsrc_nxt, nsrc_nxt} =
        {gain_sixteen_select_i, rectifier_enable_i, single_run_select_i, offset_source_select_i,
        tunable_filter_enable_i, filter_shape_select_i, bandpass_coef_source_i, notch_coef_source_i};
    end
  end

  // register configuration; coefficient sources come up on rom
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      {en_r, acsel_r, dcsel_r, gain_r, rect_r, single_r, ofsel_r, filt_r, shape_r} <= '0;
      {ch_r, dcin_r, count_r, shift_r, thr_r} <= {RST_CHANNEL, RST_DC_INPUT, RST_COUNT, RST_SHIFT, RST_THRESHOLD};
      {bpsrc_r, nsrc_r} <= {RST_COEF_ROM, RST_COEF_ROM};  // [R16]
    end else begin
      {en_r, ch_r, acsel_r, dcsel_r, dcin_r, count_r, shift_r, thr_r} <=
        {en_nxt, ch_nxt, acsel_nxt, dcsel_nxt, dcin_nxt, count_nxt, shift_nxt, thr_nxt};
      {gain_r, rect_r, single_r, ofsel_r, filt_r, shape_r, bpsrc_r, nsrc_r} <=
        {gain_nxt, rect_nxt, single_nxt, ofsel_nxt, filt_nxt, shape_nxt, bpsrc_nxt, nsrc_nxt};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source selection
  logic [SAMPLE_W-1:0]        ac_raw;     // channel ac sample
  logic [SAMPLE_W-1:0]        ac_used;    // after optional filter
  logic signed [SAMPLE_W:0]   sel_s;      // sample fed to conditioning
  logic [SAMPLE_W-1:0]        offset_r, offset_nxt;
  logic [SAMPLE_W-1:0]        ac_out_r;   // sample sent to the filter
  logic signed [COND_W-1:0]   cond_s;     // conditioned sample

  // filter runs outside; it needs the selected channel's ac sample
  always_comb begin
    ac_raw  = transmit_ac_signal_i[ch_r];                // [R7]
    ac_used = filt_r ? filtered_ac_i : ac_raw;           // [R15]
    if (acsel_r) begin
      sel_s = $signed({ac_used[SAMPLE_W-1], ac_used});   // [R17]
    end else if (!dcsel_r) begin
      sel_s = $signed({receive_dc_signal_i[ch_r][SAMPLE_W-1], receive_dc_signal_i[ch_r]});  // [R17]
    end else begin
      // offset removed from the transmit dc path only
      sel_s = $signed({transmit_dc_signal_i[ch_r][SAMPLE_W-1], transmit_dc_signal_i[ch_r]})
            - $signed({offset_r[SAMPLE_W-1], offset_r});  // [R17]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ac_out_r <= OFFSET_ZERO;
    end else begin
      ac_out_r <= ac_raw;
    end
  end

  lmrt_condition u_cond (
    .sample_i              (sel_s),
    .gain_sixteen_select_i (gain_r),
    .rectifier_enable_i    (rect_r),
    .cond_o                (cond_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // integrator sequencer
  lmrt_state_t             state_r, state_nxt;
  logic signed [ACC_W-1:0] acc_r, acc_nxt;     // running sum
  logic signed [ACC_W-1:0] acc_sum;            // sum including this sample
  logic [CNT_W-1:0]        cnt_r, cnt_nxt;     // samples taken so far
  logic [RES_W-1:0]        result_r, result_nxt;
  logic                    over_r, over_nxt;
  logic [RES_W-1:0]        scaled;             // from scaler
  logic                    scaled_over;        // from scaler
  logic                    latch;              // integration ends now

  lmrt_scale u_scale (
    .acc_i            (acc_sum),
    .shift_code_i     (shift_r),
    .threshold_code_i (thr_r),
    .result_o         (scaled),
    .over_o           (scaled_over)
  );

  // one sample per strobe; last sample is folded in at the latch
  always_comb begin
    state_nxt  = state_r;
    acc_nxt    = acc_r;
    cnt_nxt    = cnt_r;
    offset_nxt = offset_r;
    result_nxt = result_r;
    over_nxt   = over_r;
    latch      = 1'b0;
    acc_sum    = acc_r + ACC_W'(cond_s);  // wraps at 27 bits [R3]
    case (state_r)
      LMRT_IDLE: begin
        result_nxt = RES_ZERO;  // disabled meter shows zero
        over_nxt   = 1'b0;
        acc_nxt    = '0;
        cnt_nxt    = '0;
        if (en_r) begin
          state_nxt  = LMRT_RUN;  // [R9]
          offset_nxt = ofsel_r ? OFFSET_ZERO : dc_offset_word_i;  // [R14]
        end
      end
      LMRT_RUN: begin
        if (!en_r) begin
          state_nxt = LMRT_IDLE;  // [R9]
        end else if (sample_strobe_i) begin
          if (cnt_r == count_r) begin
            latch      = 1'b1;            // [R8]
            result_nxt = scaled;          // [R20]
            over_nxt   = scaled_over;     // [R5]
            acc_nxt    = '0;
            cnt_nxt    = '0;
            state_nxt  = single_r ? LMRT_HOLD : LMRT_RUN;  // [R13] [R18]
          end else begin
            acc_nxt = acc_sum;
            cnt_nxt = cnt_r + CNT_W'(1);
          end
        end
      end
      LMRT_HOLD: begin
        if (!en_r) begin
          state_nxt = LMRT_IDLE;  // a fresh 0 to 1 is needed [R19]
        end
      end
      default: begin
        state_nxt = LMRT_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_r <= LMRT_IDLE;
      {acc_r, cnt_r, over_r} <= '0;
      {offset_r, result_r} <= {OFFSET_ZERO, RES_ZERO};
    end else begin
      state_r <= state_nxt;
      {acc_r, cnt_r, offset_r, result_r, over_r} <= {acc_nxt, cnt_nxt, offset_nxt, result_nxt, over_nxt};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // done flag and event
  logic              done_r, done_nxt;
  logic [HOLD_W-1:0] hold_r, hold_nxt;   // cycles left before self-clear
  logic              event_r;

  // clears first, a new completion last so the set wins
  always_comb begin
    done_nxt = done_r;
    hold_nxt = hold_r;
    if (!en_r) begin
      done_nxt = 1'b0;  // [R19]
      hold_nxt = HOLD_ZERO;
    end else if (done_r && !single_r && hold_r != HOLD_ZERO) begin
      hold_nxt = hold_r - HOLD_ONE;
      if (hold_r == HOLD_ONE) begin
        done_nxt = 1'b0;  // [R18]
      end
    end
    if (latch) begin
      done_nxt = 1'b1;  // [R10]
      hold_nxt = DONE_HOLD_CYC;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      {done_r, hold_r, event_r} <= '0;
    end else begin
      done_r  <= done_nxt;
      hold_r  <= hold_nxt;
      event_r <= latch;  // interrupt source [R18]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign result_low_bits_o        = result_r[7:0];   // [R1]
  assign result_high_bits_o       = result_r[15:8];  // [R1]
  assign over_threshold_flag_o    = over_r;
  assign measurement_done_flag_o  = done_r;
  assign measurement_done_event_o = event_r;
  assign meter_ac_sample_o        = ac_out_r;
  assign tunable_filter_enable_o  = filt_r;
  assign filter_shape_select_o    = shape_r;
  assign filter_coef_from_rom_o   = shape_r ? bpsrc_r : nsrc_r;  // [R16]
  assign meter_channel_o          = ch_r;
  assign dc_input_select_o        = dcin_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks; helper logic only for them
  logic [HOLD_W-1:0]       done_len_r;  // cycles done has stood since set
  logic signed [ACC_W-1:0] ref_clamp;   // sum shifted by the clamp value
  assign ref_clamp = acc_sum >>> SHIFT_CLAMP;
  // restarts on each completion so a retrigger is not seen as overdue
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || latch || !done_r) begin
      done_len_r <= HOLD_ZERO;
    end else begin
      done_len_r <= done_len_r + HOLD_ONE;
    end
  end
  a_result_bytes: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // [R1]
    latch |=> {result_high_bits_o, result_low_bits_o} == $past(scaled))
    else $error("result bytes do not match latched value");
  a_result_sat: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // [R2]
    (latch && (acc_sum >>> shift_r) > ACC_RES_MAX && shift_r < SHIFT_CLAMP) |=> result_r == RES_POS_FULL)
    else $error("positive overflow not held at full scale");
  a_shift_clamp: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // [R4]
    (latch && shift_r >= SHIFT_CLAMP && ref_clamp <= ACC_RES_MAX && ref_clamp >= ACC_RES_MIN)
    |=> result_r == $past(ref_clamp[RES_W-1:0]))
    else $error("large shift code not scaled by 2048");
  a_over_thresh: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // [R5]
    (latch && thr_r == 3'h0 && scaled != RES_ZERO) |=> over_threshold_flag_o)
    else $error("nonzero result not over zero threshold");
  a_count_len: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // [R8]
    latch |-> (cnt_r == count_r && sample_strobe_i && state_r == LMRT_RUN))
    else $error("integration ended at wrong count");
  a_enable_stop: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // [R9]
    (!en_r && state_r != LMRT_IDLE) |=> (state_r == LMRT_IDLE && !done_r) ##1 result_r == RES_ZERO)
    else $error("disable did not stop the meter");
  a_done_set: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // [R10]
    latch |=> (done_r && event_r) ##1 !event_r)
    else $error("completion did not raise flag and event");
  a_rect_pos: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // [R12]
    rect_r |-> cond_s >= 0)
    else $error("rectified sample negative");
  a_cont_restart: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // [R18]
    (latch && !single_r) |=> state_r == LMRT_RUN && acc_r == '0)
    else $error("continuous mode did not restart");
  a_done_selfclr: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // [R18]
    (!single_r && en_r && done_r && done_len_r == DONE_HOLD_CYC - HOLD_ONE && !latch) |=> !done_r)
    else $error("done flag not cleared after hold time");
  a_single_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)  // [R19]
    (state_r == LMRT_HOLD && en_r) |=> done_r && state_r == LMRT_HOLD)
    else $error("single mode flag or state not held");
  c_cont_done: cover property (@(posedge ref_clk_i) disable iff (rst_i) latch && !single_r);
  c_single_done: cover property (@(posedge ref_clk_i) disable iff (rst_i) latch && single_r);
  c_over_set: cover property (@(posedge ref_clk_i) disable iff (rst_i) latch && scaled_over);
  c_clamp_used: cover property (@(posedge ref_clk_i) disable iff (rst_i) latch && shift_r > SHIFT_CLAMP);

endmodule

// *** rtl/lmrt_pkg.sv ***
package lmrt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int SAMPLE_W = 16;            // decimated sample width
  localparam int COND_W   = 22;            // after offset, gain and rectifier
  localparam int ACC_W    = 27;            // integrator width
  localparam int RES_W    = 16;            // result width
  localparam int CNT_W    = 11;            // integration count field
  localparam int CH_N     = 4;             // channels sharing the meter
  localparam int MAG_W    = RES_W + 1;     // magnitude incl. 32768

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic constants
  localparam logic [3:0]              GAIN_SHIFT    = 4'h4;  // gain of 16
  localparam logic [3:0]              SHIFT_CLAMP   = 4'hB;  // codes 1011..1111 -> 1/2048
  localparam int                      TH_STEP_LOG2  = 12;    // 12.5 % of 32768 = 4096
  localparam logic signed [ACC_W-1:0] ACC_RES_MAX   = 27'sh0007FFF;
  localparam logic signed [ACC_W-1:0] ACC_RES_MIN   = 27'sh7FF8000;
  localparam logic [RES_W-1:0]        RES_POS_FULL  = 16'h7FFF;
  localparam logic [RES_W-1:0]        RES_NEG_FULL  = 16'h8000;
  localparam logic [RES_W-1:0]        RES_ZERO      = 16'h0000;
  localparam logic [SAMPLE_W-1:0]     OFFSET_ZERO   = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // timing: done flag self-clear in continuous mode
  localparam int         CLK_PERIOD_NS  = 50;
  localparam int         DONE_HOLD_NS   = 125000;
  localparam int         HOLD_W         = 12;
  localparam logic [HOLD_W-1:0] DONE_HOLD_CYC = HOLD_W'(DONE_HOLD_NS / CLK_PERIOD_NS);
  localparam logic [HOLD_W-1:0] HOLD_ONE      = 12'h001;
  localparam logic [HOLD_W-1:0] HOLD_ZERO     = 12'h000;

  ////////////////////////////////////////////////////////////////////////////
  // reset values of the configuration fields
  localparam logic [1:0]       RST_CHANNEL   = 2'h0;
  localparam logic [3:0]       RST_DC_INPUT  = 4'h0;   // transmit dc pin input
  localparam logic [CNT_W-1:0] RST_COUNT     = 11'h000;
  localparam logic [3:0]       RST_SHIFT     = 4'h0;
  localparam logic [2:0]       RST_THRESHOLD = 3'h0;
  localparam logic             RST_COEF_ROM  = 1'b1;   // rom coefficients
  localparam logic             RST_BIT_OFF   = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // measurement sequencer states
  typedef enum logic [2:0] {
    LMRT_IDLE = 3'b001,
    LMRT_RUN  = 3'b010,
    LMRT_HOLD = 3'b100
  } lmrt_state_t;

endpackage

// *** rtl/lmrt_scale.sv ***
module lmrt_scale (
  // integrator sum
  input  wire logic signed [lmrt_pkg::ACC_W-1:0]  acc_i,
  // controls
  input  wire logic [3:0]                         shift_code_i,
  input  wire logic [2:0]                         threshold_code_i,
  // scaled result and compare
  output logic [lmrt_pkg::RES_W-1:0]              result_o,
  output logic                                    over_o
);
  import lmrt_pkg::*;

  logic [3:0]               eff_shift;  // clamped shift amount
  logic signed [ACC_W-1:0]  shifted_s;  // sum after right shift
  logic [MAG_W-1:0]         ext_res;    // result widened by one bit
  logic [MAG_W-1:0]         mag;        // absolute value of result
  logic [MAG_W-1:0]         thr;        // threshold in result units

  ////////////////////////////////////////////////////////////////////////////
  // shift, saturate to 16 bits, compare magnitude with threshold
  always_comb begin
    eff_shift = (shift_code_i >= SHIFT_CLAMP) ? SHIFT_CLAMP : shift_code_i;  // [R4]
    shifted_s = acc_i >>> eff_shift;  // [R3] [R21]
    // saturation keeps a too-small shift from folding sign
    if (shifted_s > ACC_RES_MAX) begin
      result_o = RES_POS_FULL;  // [R2]
    end else if (shifted_s < ACC_RES_MIN) begin
      result_o = RES_NEG_FULL;  // [R2]
    end else begin
      result_o = shifted_s[RES_W-1:0];  // [R1]
    end
    ext_res = {result_o[RES_W-1], result_o};
    mag     = result_o[RES_W-1] ? (~ext_res + MAG_W'(1)) : ext_res;
    thr     = MAG_W'(threshold_code_i) << TH_STEP_LOG2;  // [R6]
    over_o  = mag > thr;  // [R5]
  end

endmodule

// *** tb/lmrt_tb.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import lmrt_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // design ports, all driven from time zero
  logic [CH_N-1:0][SAMPLE_W-1:0] transmit_ac_signal_i = '0, receive_dc_signal_i = '0, transmit_dc_signal_i = '0;
  logic [SAMPLE_W-1:0] filtered_ac_i = '0, dc_offset_word_i = 16'h0100, meter_ac_sample_o;
  logic ref_clk_i = '0, rst_i = '1, sample_strobe_i = '0, cfg_load_i = '0, meter_enable_i = '0;
  logic meter_ac_dc_select_i = '0, dc_path_select_i = '0, gain_sixteen_select_i = '0, rectifier_enable_i = '0;
  logic single_run_select_i = '0, offset_source_select_i = '0, tunable_filter_enable_i = '0;
  logic filter_shape_select_i = '0, bandpass_coef_source_i = '1, notch_coef_source_i = '1;
  logic over_threshold_flag_o, measurement_done_flag_o, measurement_done_event_o;
  logic tunable_filter_enable_o, filter_shape_select_o, filter_coef_from_rom_o;
  logic [1:0] meter_channel_select_i = '0, meter_channel_o;
  logic [3:0] dc_input_select_i = '0, shift_factor_code_i = '0, dc_input_select_o;
  logic [2:0] threshold_code_i = '0;
  logic [CNT_W-1:0] integration_count_i = '0;
  logic [7:0] result_low_bits_o, result_high_bits_o;
  int num_errors = 0, checks = 0;
  lmrt_meter DUT (.*);
  initial forever #25 ref_clk_i = ~ref_clk_i;
  ////////////////////////////////////////////////////////////////////////////
  // compare and report
  task automatic cmp(input logic [15:0] got, exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, exp);
    cmp({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // strobes two cycles apart, the closest spacing allowed
  task automatic pulse();
    @(posedge ref_clk_i) sample_strobe_i <= 1'b1;
    @(posedge ref_clk_i) sample_strobe_i <= 1'b0;
  endtask
  task automatic load(input logic en);
    @(posedge ref_clk_i) {cfg_load_i, meter_enable_i} <= {1'b1, en};
    @(posedge ref_clk_i) cfg_load_i <= 1'b0;
  endtask
  // mode bits: gain, rectifier, zero offset, single run; src 0 rx dc, 1 tx dc, 2 ac
  task automatic meas(input logic [15:0] smp, input logic [1:0] src, input logic [10:0] cnt,
                      input logic [3:0] sh, input logic [2:0] th, input logic [3:0] mode);
    longint x, s;
    logic [15:0] e;
    int n;
    logic [CH_N-1:0][SAMPLE_W-1:0] ac, rx, tx;
    // unselected paths carry the inverse so a wrong pick shows
    ac = {CH_N{~smp}};
    rx = ac;
    tx = ac;
    if (src == 2'h2) ac[sh[1:0]] = sh[2] ? ~smp : smp;  // filter on: only the filtered path is right
    else if (src[0]) tx[sh[1:0]] = smp;
    else rx[sh[1:0]] = smp;
    x = $signed(smp);
    if (src == 2'h1 && !mode[1]) x = x - 256;
    if (mode[3]) x = x * 16;
    if (mode[2] && x < 0) x = -x;
    s = (x * (int'(cnt) + 1)) >>> (sh > 11 ? 11 : sh);
    e = s > 32767 ? 16'h7FFF : s < -32768 ? 16'h8000 : 16'(s);
    x = $signed(e);
    @(posedge ref_clk_i) begin
      {transmit_ac_signal_i, receive_dc_signal_i, transmit_dc_signal_i, filtered_ac_i} <=
        {ac, rx, tx, sh[2] ? smp : ~smp};
      {meter_channel_select_i, meter_ac_dc_select_i, dc_path_select_i, dc_input_select_i} <= {sh[1:0], src, sh};
      {integration_count_i, shift_factor_code_i, threshold_code_i} <= {cnt, sh, th};
      {gain_sixteen_select_i, rectifier_enable_i, offset_source_select_i, single_run_select_i} <= mode;
      {tunable_filter_enable_i, filter_shape_select_i, bandpass_coef_source_i, notch_coef_source_i} <=
        {sh[2:1], sh[0], !sh[0]};
    end
    load(1'b1);
    @(negedge ref_clk_i) cmp({8'h00, meter_channel_o, dc_input_select_o, tunable_filter_enable_o,
      filter_shape_select_o}, {8'h00, sh[1:0], sh, sh[2:1]});
    cmp_bit(filter_coef_from_rom_o, sh[1] ? sh[0] : !sh[0]);
    repeat (cnt + 1) pulse();
    n = 0;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (measurement_done_flag_o !== 1'b1 && n < 9);
    if (n == 9) begin
      num_errors++;
      conclude();
    end
    cmp_bit(measurement_done_event_o, 1'b1);
    cmp({result_high_bits_o, result_low_bits_o}, e);
    cmp_bit(over_threshold_flag_o, (x < 0 ? -x : x) > th * 4096);
    cmp(meter_ac_sample_o, ac[sh[1:0]]);
    if (mode[0]) begin
      // single run: a later strobe must not disturb the held result
      pulse();
      @(negedge ref_clk_i) cmp({result_high_bits_o, result_low_bits_o}, e);
      cmp_bit(measurement_done_flag_o, 1'b1);
    end else begin
      n = 0;
      while (measurement_done_flag_o === 1'b1 && n < 3000) begin
        @(negedge ref_clk_i);
        n++;
      end
      cmp(16'(n), 16'h09C4);  // 125 us of 50 ns cycles
      if (n == 3000) conclude();
    end
    load(1'b0);
    repeat (3) @(negedge ref_clk_i);
    cmp({result_high_bits_o, result_low_bits_o}, 16'h0000);
    cmp_bit(measurement_done_flag_o, 1'b0);
    $display("test done at %0t: src %0d shift %0d", $time, src, sh);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(negedge ref_clk_i) cmp_bit(filter_coef_from_rom_o, 1'b1);
    cmp({result_high_bits_o, result_low_bits_o}, 16'h0000);
    for (int k = 0; k < 16; k++) meas(16'h1000, 2'h0, 11'h007, 4'(k), 3'(k), 4'h1);
    meas(16'hFF00, 2'h0, 11'h000, 4'h0, 3'h0, 4'h9);
    meas(16'hFF00, 2'h0, 11'h000, 4'h0, 3'h1, 4'hD);
    meas(16'hFF00, 2'h0, 11'h00F, 4'h0, 3'h7, 4'h9);
    meas(16'h0300, 2'h1, 11'h001, 4'h1, 3'h0, 4'h1);
    meas(16'h0300, 2'h1, 11'h001, 4'h1, 3'h0, 4'h3);
    meas(16'h0040, 2'h2, 11'h003, 4'h0, 3'h0, 4'h0);
    meas(16'h0040, 2'h2, 11'h003, 4'h4, 3'h0, 4'h1);
    conclude();
  end
endmodule
